// ### design/mccd_pkg.sv
// constants shared by the memory controller command decoder
// assumes nothing beyond a single clock domain
package mccd_pkg;
  // ----------------------------------------------------------------
  // command byte fields
  // ----------------------------------------------------------------
  localparam int CMD_W = 8;
  localparam int BASIC_MSB = 7;
  localparam int BASIC_LSB = 6;
  localparam int SUB_MSB = 5;
  localparam logic [1:0] SUB_SEL = 2'h0;
  // ----------------------------------------------------------------
  // descriptor layout: [7] valid, [6:4] data type, [3:2] start byte, [1] buffered
  // ----------------------------------------------------------------
  localparam int DESC_VALID = 7;
  localparam int DESC_TYPE_MSB = 6;
  localparam int DESC_TYPE_LSB = 4;
  localparam int DESC_BYTE_MSB = 3;
  localparam int DESC_BYTE_LSB = 2;
  localparam int DESC_BUF = 1;
  localparam int DESC_MULTI = 0;
  localparam logic [2:0] TYPE_INCR = 3'h7;
  localparam logic [1:0] BYTE_DONE = 2'h0;
  // ----------------------------------------------------------------
  // buffer and ram sizes
  // ----------------------------------------------------------------
  localparam int BUF_BYTES = 32;
  localparam int MULTI_ENTRIES = 10;
  localparam int MULTI_ENTRY_BYTES = 3;
  localparam int RAM_WORDS = 64;
  localparam int RAM_AW = 6;
  localparam logic [RAM_AW-1:0] BUF_BASE = 6'h20;
  localparam logic [5:0] COUNT_RESET = 6'h00;
  // host status bits
  localparam int STAT_WAIT = 0;
  localparam int STAT_ILLEGAL = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_W = 8;
endpackage

// ### design/mccd_cmd_rom.sv
// fixed command tables, basic and sub-command, each entry two bytes
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module mccd_cmd_rom (
  input wire logic [7:0] cmd,
  output logic [7:0] descriptor,
  output logic [7:0] start_low
);
  logic [1:0] basic_index;
  logic [5:0] sub_index;
  logic [15:0] entry;

  assign basic_index = cmd[mccd_pkg::BASIC_MSB:mccd_pkg::BASIC_LSB];
  assign sub_index = cmd[mccd_pkg::SUB_MSB:0];

  always_comb begin
    entry = 16'h0000;
    if (basic_index != mccd_pkg::SUB_SEL) begin
      case (basic_index)
        2'h1: entry = 16'hA810;
        2'h2: entry = 16'hAC20;
        2'h3: entry = 16'h8030;
        default: entry = 16'h0000;
      endcase
    end else begin
      case (sub_index)
        6'h01: entry = 16'h8040;
        6'h02: entry = 16'hC250;
        6'h03: entry = 16'hC361;
        6'h04: entry = 16'hF470;
        default: entry = 16'h0000;
      endcase
    end
  end

  assign descriptor = entry[15:8];
  assign start_low = entry[7:0];
endmodule
`default_nettype wire

// ### design/mccd_decoder.sv
// command interpreter and data receiver of the memory controller
// host writes bytes through a byte buffer; executor handshakes on exec_*
`timescale 1ns/1ps
`default_nettype none
module mccd_decoder #(
  parameter int BUF_BYTES = mccd_pkg::BUF_BYTES,
  parameter int MULTI_ENTRIES = mccd_pkg::MULTI_ENTRIES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic host_byte_buffer_valid,
  input wire logic host_byte_buffer_is_cmd,
  input wire logic [7:0] host_byte_buffer_data,
  input wire logic exec_done,
  input wire logic exec_more,
  input wire logic [7:0] exec_mem_status,
  output logic host_byte_buffer_ready,
  output logic [7:0] host_status,
  output logic [7:0] mem_status,
  output logic exec_start,
  output logic [7:0] exec_start_low,
  output logic [7:0] exec_cmd,
  output logic [5:0] buf_count,
  output logic [5:0] buf_pointer,
  output logic buf_full
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // table lookup
  // ----------------------------------------------------------------
  logic [7:0] rom_desc;
  logic [7:0] rom_low;
  mccd_cmd_rom u_rom (
    .cmd(host_byte_buffer_data),
    .descriptor(rom_desc),
    .start_low(rom_low)
  );

  // data destination table: four bytes per type
  function automatic logic [5:0] dest_lookup(input logic [2:0] dtype, input logic [1:0] bnum);
    logic [5:0] d;
    d = {1'b0, dtype[1:0], 1'b0, bnum};
    return d;
  endfunction

  typedef enum {S_IDLE, S_COLLECT, S_EXEC} mccd_state_type;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mccd_state_type state, next_state;
  logic [7:0] desc, next_desc;
  logic [1:0] byte_num, next_byte_num;
  logic [5:0] dest, next_dest;
  logic [5:0] count, next_count;
  logic [5:0] pointer, next_pointer;
  logic [7:0] hstat, next_hstat;
  logic [7:0] mstat, next_mstat;
  logic start, next_start;
  logic [7:0] low, next_low;
  logic [7:0] cmd_q, next_cmd_q;
  logic ready, next_ready;
  logic full, next_full;
  logic [7:0] ram [mccd_pkg::RAM_WORDS];
  logic ram_we;
  logic [5:0] ram_addr;
  logic [5:0] limit;
  logic take;

  assign take = host_byte_buffer_valid && ready;
  assign limit = desc[mccd_pkg::DESC_MULTI] ?
                 6'(MULTI_ENTRIES * mccd_pkg::MULTI_ENTRY_BYTES) : 6'(BUF_BYTES);

  always_comb begin
    next_state = state;
    next_desc = desc;
    next_byte_num = byte_num;
    next_dest = dest;
    next_count = count;
    next_pointer = pointer;
    next_hstat = hstat;
    next_mstat = exec_mem_status;
    next_start = 1'b0;
    next_low = low;
    next_cmd_q = cmd_q;
    next_ready = ready;
    next_full = full;
    ram_we = 1'b0;
    // buffered bytes land at the pointer
    ram_addr = desc[mccd_pkg::DESC_BUF] ? pointer : dest;
    case (state)
      S_IDLE: begin
        if (take && host_byte_buffer_is_cmd) begin
          next_hstat[mccd_pkg::STAT_WAIT] = 1'b0;
          next_hstat[mccd_pkg::STAT_ILLEGAL] = 1'b0;
          next_cmd_q = host_byte_buffer_data;
          next_low = rom_low;
          next_desc = rom_desc;
          next_byte_num = rom_desc[mccd_pkg::DESC_BYTE_MSB:mccd_pkg::DESC_BYTE_LSB];
          next_count = mccd_pkg::COUNT_RESET;
          next_pointer = mccd_pkg::BUF_BASE;
          next_full = 1'b0;
          if (!rom_desc[mccd_pkg::DESC_VALID]) begin
            next_hstat[mccd_pkg::STAT_ILLEGAL] = 1'b1;
            next_hstat[mccd_pkg::STAT_WAIT] = 1'b1;
          end else if (next_byte_num == mccd_pkg::BYTE_DONE) begin
            next_start = 1'b1;
            next_ready = 1'b0;
            next_hstat[mccd_pkg::STAT_BUSY] = 1'b1;
            next_state = S_EXEC;
          end else begin
            if (rom_desc[mccd_pkg::DESC_TYPE_MSB:mccd_pkg::DESC_TYPE_LSB] != mccd_pkg::TYPE_INCR)
              next_dest = dest_lookup(rom_desc[mccd_pkg::DESC_TYPE_MSB:mccd_pkg::DESC_TYPE_LSB],
                                      next_byte_num);
            else
              next_dest = mccd_pkg::BUF_BASE;
            next_state = S_COLLECT;
          end
        end else if (take) begin
          // data while waiting for a command is illegal
          next_hstat[mccd_pkg::STAT_ILLEGAL] = 1'b1;
        end
      end
      S_COLLECT: begin
        if (take && !host_byte_buffer_is_cmd) begin
          ram_we = 1'b1;
          next_byte_num = byte_num + 2'h1;
          if (desc[mccd_pkg::DESC_BUF]) begin
            next_pointer = pointer + 6'h01;
            next_count = count + 6'h01;
            next_full = (count + 6'h01) >= limit;
          end
          if (desc[mccd_pkg::DESC_TYPE_MSB:mccd_pkg::DESC_TYPE_LSB] == mccd_pkg::TYPE_INCR)
            next_dest = dest + 6'h01;
          else
            next_dest = dest_lookup(desc[mccd_pkg::DESC_TYPE_MSB:mccd_pkg::DESC_TYPE_LSB],
                                    next_byte_num);
          // execute when the last byte of the round is in or the buffer is full
          if (next_byte_num == mccd_pkg::BYTE_DONE || next_full) begin
            next_start = 1'b1;
            next_ready = 1'b0;
            next_hstat[mccd_pkg::STAT_BUSY] = 1'b1;
            next_state = S_EXEC;
          end
        end else if (take) begin
          next_hstat[mccd_pkg::STAT_ILLEGAL] = 1'b1;
        end
      end
      S_EXEC: begin
        if (exec_done) begin
          next_ready = 1'b1;
          next_hstat[mccd_pkg::STAT_BUSY] = 1'b0;
          next_hstat[mccd_pkg::STAT_WAIT] = 1'b1;
          next_state = S_IDLE;
        end else if (exec_more && !full) begin
          next_ready = 1'b1;
          next_byte_num = 2'h1;
          // stale destination would overwrite the byte zero slot
          if (desc[mccd_pkg::DESC_TYPE_MSB:mccd_pkg::DESC_TYPE_LSB] != mccd_pkg::TYPE_INCR)
            next_dest = dest_lookup(desc[mccd_pkg::DESC_TYPE_MSB:mccd_pkg::DESC_TYPE_LSB],
                                    2'h1);
          next_state = S_COLLECT;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= S_IDLE;
      desc <= 8'h00;
      byte_num <= 2'h0;
      dest <= 6'h00;
      count <= mccd_pkg::COUNT_RESET;
      pointer <= mccd_pkg::BUF_BASE;
      hstat <= 8'h01;
      mstat <= 8'h00;
      start <= 1'b0;
      low <= 8'h00;
      cmd_q <= 8'h00;
      ready <= 1'b1;
      full <= 1'b0;
    end else begin
      state <= next_state;
      desc <= next_desc;
      byte_num <= next_byte_num;
      dest <= next_dest;
      count <= next_count;
      pointer <= next_pointer;
      hstat <= next_hstat;
      mstat <= next_mstat;
      start <= next_start;
      low <= next_low;
      cmd_q <= next_cmd_q;
      ready <= next_ready;
      full <= next_full;
    end
  end

  // ram has no reset; contents only meaningful once written
  always_ff @(posedge core_clk) begin
    if (ram_we)
      ram[ram_addr] <= host_byte_buffer_data;
  end

  assign host_byte_buffer_ready = ready;
  assign host_status = hstat;
  assign mem_status = mstat;
  assign exec_start = start;
  assign exec_start_low = low;
  assign exec_cmd = cmd_q;
  assign buf_count = count;
  assign buf_pointer = pointer;
  assign buf_full = full;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_bad_cmd;
    take && host_byte_buffer_is_cmd && state == S_IDLE && !rom_desc[mccd_pkg::DESC_VALID];
  endsequence
  property p_illegal;
    @(posedge core_clk) disable iff (!rst_sync)
      s_bad_cmd |=> host_status[mccd_pkg::STAT_ILLEGAL] && !exec_start && state == S_IDLE;
  endproperty
  a_illegal: assert property (p_illegal) else $error("bad command not flagged");
  property p_basic;
    @(posedge core_clk) disable iff (!rst_sync)
      take && host_byte_buffer_is_cmd && state == S_IDLE && host_byte_buffer_data[7:6] != 2'h0
      |=> desc[mccd_pkg::DESC_VALID];
  endproperty
  a_basic: assert property (p_basic) else $error("basic command not decoded");
  property p_sub;
    @(posedge core_clk) disable iff (!rst_sync)
      take && host_byte_buffer_is_cmd && state == S_IDLE && host_byte_buffer_data == 8'h05
      |=> host_status[mccd_pkg::STAT_ILLEGAL];
  endproperty
  a_sub: assert property (p_sub) else $error("sub index not used");
  property p_ptr;
    @(posedge core_clk) disable iff (!rst_sync)
      state == S_COLLECT && take && !host_byte_buffer_is_cmd && desc[mccd_pkg::DESC_BUF]
      |=> buf_pointer == $past(buf_pointer) + 6'h01 && buf_count == $past(buf_count) + 6'h01;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer or count did not advance");
  property p_count;
    @(posedge core_clk) disable iff (!rst_sync)
      buf_pointer == mccd_pkg::BUF_BASE + buf_count;
  endproperty
  a_count: assert property (p_count) else $error("count and pointer disagree");
  property p_bound;
    @(posedge core_clk) disable iff (!rst_sync) buf_count <= 6'(BUF_BYTES);
  endproperty
  a_bound: assert property (p_bound) else $error("buffer overrun");
  property p_wait_start;
    @(posedge core_clk) disable iff (!rst_sync)
      exec_start |-> $past(state) != S_EXEC && !host_byte_buffer_ready;
  endproperty
  a_wait_start: assert property (p_wait_start) else $error("start while still receiving");
  property p_done;
    @(posedge core_clk) disable iff (!rst_sync)
      state == S_EXEC && exec_done |=> host_byte_buffer_ready && host_status[mccd_pkg::STAT_WAIT];
  endproperty
  a_done: assert property (p_done) else $error("no return to waiting");
  property p_more;
    @(posedge core_clk) disable iff (!rst_sync)
      state == S_EXEC && !exec_done && exec_more && !buf_full |=> state == S_COLLECT ##0 ready;
  endproperty
  a_more: assert property (p_more) else $error("no return to reception");
  property p_incr;
    @(posedge core_clk) disable iff (!rst_sync)
      state == S_COLLECT && take && !host_byte_buffer_is_cmd &&
      desc[mccd_pkg::DESC_TYPE_MSB:mccd_pkg::DESC_TYPE_LSB] == mccd_pkg::TYPE_INCR
      |=> dest == $past(dest) + 6'h01;
  endproperty
  a_incr: assert property (p_incr) else $error("type seven did not increment");
  property p_store;
    @(posedge core_clk) disable iff (!rst_sync)
      ram_we |=> ram[$past(ram_addr)] == $past(host_byte_buffer_data) &&
      (!$past(desc[mccd_pkg::DESC_BUF]) || $past(ram_addr) == $past(buf_pointer));
  endproperty
  a_store: assert property (p_store) else $error("data byte not stored");
endmodule
`default_nettype wire

// ### verification/mccd_host_model.sv
// host side model: offers command and data bytes one at a time
// assumes the decoder takes a byte on a rising edge with valid and ready high
`timescale 1ns/1ps
`default_nettype none
module mccd_host_model (
  input wire logic core_clk,
  input wire logic ready,
  output logic valid,
  output logic is_cmd,
  output logic [7:0] data
);
  initial begin
    valid = 1'b0;
    is_cmd = 1'b0;
    data = 8'hA5;
  end
  task automatic send(input logic cmd, input logic [7:0] b);
    logic r;
    valid = 1'b1;
    is_cmd = cmd;
    data = b;
    do begin
      @(negedge core_clk) r = ready;
      @(posedge core_clk);
    end while (!r);
    #2;
  endtask
  // released bus shows the inverse, never a stale byte
  task automatic idle();
    valid = 1'b0;
    data = ~data;
  endtask
endmodule
`default_nettype wire

// ### verification/memory_controller_command_decoder_tb_top.sv
// self-checking bench for the command decoder, host model on the byte buffer
// assumes the executor side is played by the bench through exec_* pulses
`timescale 1ns/1ps
`default_nettype none
module memory_controller_command_decoder_tb_top;
  logic core_clk;
  logic resetn;
  logic valid;
  logic is_cmd;
  logic [7:0] data;
  logic exec_done;
  logic exec_more;
  logic [7:0] exec_mem_status;
  logic ready;
  logic [7:0] host_status;
  logic [7:0] mem_status;
  logic exec_start;
  logic [7:0] exec_start_low;
  logic [7:0] exec_cmd;
  logic [5:0] buf_count;
  logic [5:0] buf_pointer;
  logic buf_full;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam int LIMIT = 3000;

  mccd_decoder u_mccd_decoder (
    .core_clk(core_clk), .resetn(resetn),
    .host_byte_buffer_valid(valid), .host_byte_buffer_is_cmd(is_cmd),
    .host_byte_buffer_data(data), .exec_done(exec_done), .exec_more(exec_more),
    .exec_mem_status(exec_mem_status), .host_byte_buffer_ready(ready),
    .host_status(host_status), .mem_status(mem_status), .exec_start(exec_start),
    .exec_start_low(exec_start_low), .exec_cmd(exec_cmd), .buf_count(buf_count),
    .buf_pointer(buf_pointer), .buf_full(buf_full)
  );
  mccd_host_model u_mccd_host_model (
    .core_clk(core_clk), .ready(ready), .valid(valid), .is_cmd(is_cmd), .data(data)
  );

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("counts: checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      close_out();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic pulse(input logic more);
    exec_done = !more;
    exec_more = more;
    step(1);
    exec_done = 1'b0;
    exec_more = 1'b0;
  endtask
  task automatic bit_is(input logic b, input logic e);
    check({7'h00, b}, {7'h00, e});
  endtask
  // start pulse within a few cycles, one cycle wide, ready held low
  task automatic expect_start(input logic [7:0] cmd);
    int i;
    i = 0;
    while (exec_start !== 1'b1 && i < 4) begin
      step(1);
      i++;
    end
    bit_is(exec_start, 1'b1);
    check(exec_cmd, cmd);
    bit_is(host_status[mccd_pkg::STAT_ILLEGAL], 1'b0);
    step(1);
    bit_is(exec_start, 1'b0);
    bit_is(host_status[mccd_pkg::STAT_BUSY], 1'b1);
    bit_is(ready, 1'b0);
  endtask
  task automatic send_cmd40(input logic [7:0] d0, input logic [7:0] d1);
    u_mccd_host_model.send(1'b1, 8'h40);
    u_mccd_host_model.send(1'b0, d0);
    u_mccd_host_model.send(1'b0, d1);
    u_mccd_host_model.idle();
    expect_start(8'h40);
    check(exec_start_low, 8'h10);
  endtask
  task automatic no_start(input int n);
    repeat (n) begin
      step(1);
      bit_is(exec_start, 1'b0);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    step(1);
    resetn = 1'b0;
    step(10);
    bit_is(ready, 1'b1);
    check(host_status, 8'h01);
    check(mem_status, 8'h00);
    bit_is(exec_start, 1'b0);
    check({2'h0, buf_count}, 8'h00);
    check({2'h0, buf_pointer}, 8'h20);
    bit_is(buf_full, 1'b0);
    resetn = 1'b1;
    step(4);
    bit_is(ready, 1'b1);
    check(host_status, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_basic();
    send_cmd40(8'h11, 8'h22);
    step(3);
    bit_is(ready, 1'b0);
    exec_mem_status = 8'h3C;
    pulse(1'b0);
    step(2);
    bit_is(ready, 1'b1);
    bit_is(host_status[mccd_pkg::STAT_WAIT], 1'b1);
    check(mem_status, 8'h3C);
    $display("test basic done");
  endtask
  // more data restarts collection at byte one, three bytes
  task automatic t_more();
    send_cmd40(8'h33, 8'h44);
    pulse(1'b1);
    u_mccd_host_model.send(1'b0, 8'h55);
    u_mccd_host_model.send(1'b0, 8'h66);
    u_mccd_host_model.send(1'b0, 8'h77);
    u_mccd_host_model.idle();
    expect_start(8'h40);
    pulse(1'b0);
    step(2);
    $display("test more done");
  endtask
  // undefined entries in the sub-command table, each after a legal command
  task automatic t_illegal();
    logic [7:0] bad [3];
    bad = '{8'h00, 8'h05, 8'h3F};
    foreach (bad[k]) begin
      send_cmd40(8'h01, 8'h02);
      pulse(1'b0);
      step(2);
      u_mccd_host_model.send(1'b1, bad[k]);
      u_mccd_host_model.idle();
      no_start(3);
      bit_is(host_status[mccd_pkg::STAT_ILLEGAL], 1'b1);
    end
    $display("test illegal done");
  endtask
  // data byte with no command pending is dropped
  task automatic t_data_idle();
    send_cmd40(8'h09, 8'h0A);
    pulse(1'b0);
    step(2);
    u_mccd_host_model.send(1'b0, 8'h5A);
    u_mccd_host_model.idle();
    no_start(3);
    bit_is(host_status[mccd_pkg::STAT_ILLEGAL], 1'b1);
    // command byte while collecting is dropped, collection goes on
    u_mccd_host_model.send(1'b1, 8'h40);
    u_mccd_host_model.send(1'b1, 8'h80);
    bit_is(host_status[mccd_pkg::STAT_ILLEGAL], 1'b1);
    u_mccd_host_model.send(1'b0, 8'h01);
    u_mccd_host_model.send(1'b0, 8'h02);
    u_mccd_host_model.idle();
    bit_is(exec_start, 1'b1);
    check(exec_cmd, 8'h40);
    pulse(1'b0);
    step(2);
    $display("test data idle done");
  endtask

  // preloaded destination, then one-byte commands from both tables
  task automatic t_short();
    u_mccd_host_model.send(1'b1, 8'h04);
    u_mccd_host_model.send(1'b0, 8'hC1);
    u_mccd_host_model.send(1'b0, 8'hC2);
    u_mccd_host_model.send(1'b0, 8'hC3);
    u_mccd_host_model.idle();
    expect_start(8'h04);
    check({2'h0, buf_count}, 8'h00);
    pulse(1'b0);
    step(2);
    u_mccd_host_model.send(1'b1, 8'hC0);
    u_mccd_host_model.idle();
    expect_start(8'hC0);
    pulse(1'b0);
    step(2);
    u_mccd_host_model.send(1'b1, 8'h01);
    u_mccd_host_model.idle();
    expect_start(8'h01);
    pulse(1'b0);
    step(2);
    $display("test short done");
  endtask
  // executor pulls up to three bytes a round until the buffer is full
  task automatic t_buffered(input logic [7:0] cmd, input int total);
    int n;
    n = 0;
    u_mccd_host_model.send(1'b1, cmd);
    u_mccd_host_model.idle();
    expect_start(cmd);
    while (n < total) begin
      pulse(1'b1);
      repeat (3) begin
        if (n < total) begin
          u_mccd_host_model.send(1'b0, 8'(n));
          n++;
        end
      end
      u_mccd_host_model.idle();
      expect_start(cmd);
      check({2'h0, buf_count}, 8'(n));
      bit_is(buf_full, n >= total);
      if (n < total)
        check({2'h0, buf_pointer}, 8'(8'h20 + n));
    end
    // more data refused once full
    pulse(1'b1);
    bit_is(ready, 1'b0);
    check({2'h0, buf_count}, 8'(total));
    pulse(1'b0);
    step(2);
    bit_is(ready, 1'b1);
    $display("test buffered %h done", cmd);
  endtask

  initial begin
    resetn = 1'b0;
    exec_done = 1'b0;
    exec_more = 1'b0;
    exec_mem_status = 8'h00;
    t_reset();
    t_basic();
    t_more();
    t_illegal();
    t_data_idle();
    t_short();
    t_buffered(8'h02, mccd_pkg::BUF_BYTES);
    t_buffered(8'h03, mccd_pkg::MULTI_ENTRIES * mccd_pkg::MULTI_ENTRY_BYTES);
    // mid-run reset must bring the status, buffer and handshake outputs back
    t_reset();
    t_basic();
    close_out();
  end
endmodule
`default_nettype wire
